// File: logic/dsg_gate_if.sv
// Per-unit gate request and gate state between controller and gate stage
`timescale 1ns/1ps
`default_nettype none
interface dsg_gate_if #(
  parameter int unsigned N = 5
);
  logic [N-1:0] src_en;
  logic [N-1:0] access;
  logic [N-1:0] gate_en;
  logic [N-1:0] fault;

  modport unit (
    input  src_en,
    input  access,
    output gate_en,
    output fault
  );

  modport ctrl (
    output src_en,
    output access,
    input  gate_en,
    input  fault
  );
endinterface : dsg_gate_if
`default_nettype wire

// File: logic/dsg_gate_unit.sv
// Per-unit clock enable flops and bus fault detection
`timescale 1ns/1ps
`default_nettype none
module dsg_gate_unit #(
  parameter int unsigned N = 5
) (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  dsg_gate_if.unit  gate
);

  genvar k;
  generate
    for (k = 0; k < N; k++) begin : g_unit
      logic en_q;
      logic fault_q;
      // Fault judged against the gate actually applied, not the request
      wire  fault_d = gate.access[k] & ~en_q;

      always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
          en_q    <= 1'b0;
          fault_q <= 1'b0;
        end else begin
          en_q    <= gate.src_en[k];
          fault_q <= fault_d;
        end
      end

      assign gate.gate_en[k] = en_q;
      assign gate.fault[k]   = fault_q;
    end
  endgenerate

endmodule : dsg_gate_unit
`default_nettype wire

// File: logic/dsg_pkg.sv
// Constants, register map and types for the deep-sleep clock gating block
package dsg_pkg;

  localparam int unsigned DSG_DATA_W    = 32;
  localparam int unsigned DSG_NUM_UNITS = 5;

  // Unit index order used on every per-unit vector
  localparam int unsigned DSG_U_WDT   = 0;
  localparam int unsigned DSG_U_HIB   = 1;
  localparam int unsigned DSG_U_PWM   = 2;
  localparam int unsigned DSG_U_CAN_A = 3;
  localparam int unsigned DSG_U_CAN_B = 4;

  // Field positions of the per-unit enables
  localparam int unsigned DSG_BIT_WDT   = 3;
  localparam int unsigned DSG_BIT_HIB   = 6;
  localparam int unsigned DSG_BIT_PWM   = 20;
  localparam int unsigned DSG_BIT_CAN_A = 24;
  localparam int unsigned DSG_BIT_CAN_B = 25;

  localparam int unsigned DSG_UNIT_BIT [DSG_NUM_UNITS] = '{
    DSG_BIT_WDT, DSG_BIT_HIB, DSG_BIT_PWM, DSG_BIT_CAN_A, DSG_BIT_CAN_B
  };

  // Register byte offsets
  localparam logic [31:0] DSG_OFF_DS_EN    = 32'h0000_0120;
  localparam logic [31:0] DSG_OFF_GATES    = 32'h0000_0124;
  localparam logic [31:0] DSG_OFF_INT_STAT = 32'h0000_0128;
  localparam logic [31:0] DSG_OFF_INT_MASK = 32'h0000_012c;

  // Reset value and writable bits of the deep-sleep enables
  localparam logic [31:0] DSG_DS_EN_RESET   = 32'h0000_0040;
  localparam logic [31:0] DSG_DS_EN_RW_MASK = 32'h0310_0048;

  localparam logic [DSG_NUM_UNITS-1:0] DSG_UNITS_ZERO = 5'h00;

  localparam logic [1:0] DSG_RESP_OKAY   = 2'h0;
  localparam logic [1:0] DSG_RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    DSG_MODE_RUN,
    DSG_MODE_SLEEP,
    DSG_MODE_DEEP
  } dsg_mode_t;

endpackage : dsg_pkg

// File: logic/dsg_top.sv
// Deep-sleep unit clock gating register with AXI4-Lite access
`timescale 1ns/1ps
`default_nettype none
module dsg_top #(
  parameter int unsigned ADDR_W = 12
) (
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  // Power state and the other gating sets
  input  wire logic              deep_sleep_i,
  input  wire logic              sleep_i,
  input  wire logic              auto_gating_select_i,
  input  wire logic [31:0]       run_mode_unit_clock_enables_i,
  input  wire logic [31:0]       sleep_mode_unit_clock_enables_i,
  // Per-unit access requests and gate results
  input  wire logic [4:0]        unit_access_i,
  output logic      [4:0]        unit_clk_en_o,
  output logic      [4:0]        unit_fault_o,
  output logic                   irq_o,
  // AXI4-Lite slave
  input  wire logic [ADDR_W-1:0] s_axi_awaddr_i,
  input  wire logic              s_axi_awvalid_i,
  output logic                   s_axi_awready_o,
  input  wire logic [31:0]       s_axi_wdata_i,
  input  wire logic [3:0]        s_axi_wstrb_i,
  input  wire logic              s_axi_wvalid_i,
  output logic                   s_axi_wready_o,
  output logic      [1:0]        s_axi_bresp_o,
  output logic                   s_axi_bvalid_o,
  input  wire logic              s_axi_bready_i,
  input  wire logic [ADDR_W-1:0] s_axi_araddr_i,
  input  wire logic              s_axi_arvalid_i,
  output logic                   s_axi_arready_o,
  output logic      [31:0]       s_axi_rdata_o,
  output logic      [1:0]        s_axi_rresp_o,
  output logic                   s_axi_rvalid_o,
  input  wire logic              s_axi_rready_i
);

  localparam int unsigned NU = dsg_pkg::DSG_NUM_UNITS;

  // Highest register offset needs nine address bits
  generate
    if (ADDR_W < 9 || ADDR_W > 32) begin : g_bad_addr_w
      $error("ADDR_W must lie between 9 and 32");
    end
  endgenerate

  // Register state
  logic [31:0]   ds_en_q;
  logic [31:0]   ds_en_d;
  logic [NU-1:0] int_stat_q;
  logic [NU-1:0] int_stat_d;
  logic [NU-1:0] int_mask_q;
  logic [NU-1:0] int_mask_d;
  logic          irq_q;

  // Write channel state
  logic              aw_have_q;
  logic              aw_have_d;
  logic              w_have_q;
  logic              w_have_d;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [31:0]       w_data_q;
  logic [3:0]        w_strb_q;
  logic              awready_q;
  logic              wready_q;
  logic              bvalid_q;
  logic              bvalid_d;
  logic [1:0]        bresp_q;

  // Read channel state
  logic        arready_q;
  logic        rvalid_q;
  logic        rvalid_d;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;

  // Handshakes
  wire aw_hs = s_axi_awvalid_i & awready_q;
  wire w_hs  = s_axi_wvalid_i & wready_q;
  wire ar_hs = s_axi_arvalid_i & arready_q;
  // Write commits once both halves are held
  wire wr_do = aw_have_q & w_have_q;

  assign aw_have_d = (aw_have_q | aw_hs) & ~wr_do;
  assign w_have_d  = (w_have_q | w_hs) & ~wr_do;
  assign bvalid_d  = wr_do | (bvalid_q & ~s_axi_bready_i);
  assign rvalid_d  = ar_hs | (rvalid_q & ~s_axi_rready_i);

  // Write address decode
  wire [31:0] wa32      = 32'(aw_addr_q);
  wire        wa_ds_en  = wa32 == dsg_pkg::DSG_OFF_DS_EN;
  wire        wa_gates  = wa32 == dsg_pkg::DSG_OFF_GATES;
  wire        wa_stat   = wa32 == dsg_pkg::DSG_OFF_INT_STAT;
  wire        wa_mask   = wa32 == dsg_pkg::DSG_OFF_INT_MASK;
  wire        wa_hit    = wa_ds_en | wa_gates | wa_stat | wa_mask;

  // Read address decode
  wire [31:0] ra32      = 32'(s_axi_araddr_i);
  wire        ra_ds_en  = ra32 == dsg_pkg::DSG_OFF_DS_EN;
  wire        ra_gates  = ra32 == dsg_pkg::DSG_OFF_GATES;
  wire        ra_stat   = ra32 == dsg_pkg::DSG_OFF_INT_STAT;
  wire        ra_mask   = ra32 == dsg_pkg::DSG_OFF_INT_MASK;
  wire        ra_hit    = ra_ds_en | ra_gates | ra_stat | ra_mask;

  // Byte-lane expansion of the write strobes
  logic [31:0] wmask;
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      wmask[b*8 +: 8] = {8{w_strb_q[b]}};
    end
  end

  // Reserved bits never take a write and always read zero
  wire [31:0] ds_en_wr = (ds_en_q & ~wmask) | (w_data_q & wmask);
  assign ds_en_d = (wr_do & wa_ds_en)
                 ? (ds_en_wr & dsg_pkg::DSG_DS_EN_RW_MASK)
                 : ds_en_q;

  // Unit view of the three gating sets
  logic [NU-1:0] ds_units;
  logic [NU-1:0] run_units;
  logic [NU-1:0] slp_units;
  logic [NU-1:0] wstat_units;
  logic [NU-1:0] wdata_units;
  logic [NU-1:0] wmask_units;
  logic [NU-1:0] unit_clk_en_q_w;
  logic [31:0]   gates_word;
  logic [31:0]   stat_word;
  logic [31:0]   mask_word;

  genvar u;
  generate
    for (u = 0; u < NU; u++) begin : g_map
      localparam int unsigned P = dsg_pkg::DSG_UNIT_BIT[u];
      assign ds_units[u]    = ds_en_q[P];
      assign run_units[u]   = run_mode_unit_clock_enables_i[P];
      assign slp_units[u]   = sleep_mode_unit_clock_enables_i[P];
      assign wdata_units[u] = w_data_q[P] & wmask[P];
    end
  endgenerate

  // Status and mask use the unit layout in the same positions
  always_comb begin
    gates_word = '0;
    stat_word  = '0;
    mask_word  = '0;
    for (int i = 0; i < NU; i++) begin
      gates_word[dsg_pkg::DSG_UNIT_BIT[i]] = unit_clk_en_q_w[i];
      stat_word[dsg_pkg::DSG_UNIT_BIT[i]]  = int_stat_q[i];
      mask_word[dsg_pkg::DSG_UNIT_BIT[i]]  = int_mask_q[i];
    end
  end

  // Power state decode; the deep-sleep set only counts with auto gating
  dsg_pkg::dsg_mode_t mode;
  assign mode = (deep_sleep_i & auto_gating_select_i)
              ? dsg_pkg::DSG_MODE_DEEP
              : ((sleep_i & auto_gating_select_i)
                 ? dsg_pkg::DSG_MODE_SLEEP
                 : dsg_pkg::DSG_MODE_RUN);

  logic [NU-1:0] sel_units;
  always_comb begin
    case (mode)
      dsg_pkg::DSG_MODE_DEEP:  sel_units = ds_units;
      dsg_pkg::DSG_MODE_SLEEP: sel_units = slp_units;
      dsg_pkg::DSG_MODE_RUN:   sel_units = run_units;
      default:                 sel_units = run_units;
    endcase
  end

  // Gate stage
  dsg_gate_if #(.N(NU)) gate_bus ();

  assign gate_bus.src_en = sel_units;
  assign gate_bus.access = unit_access_i;

  dsg_gate_unit #(
    .N (NU)
  ) u_gate (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .gate    (gate_bus)
  );

  // Applied enables trail the selection by one edge
  assign unit_clk_en_q_w = gate_bus.gate_en;

  // Fault events are sticky; a set in the clearing cycle survives
  assign wstat_units = (wr_do & wa_stat) ? wdata_units
                                         : dsg_pkg::DSG_UNITS_ZERO;
  assign int_stat_d  = (int_stat_q & ~wstat_units) | gate_bus.fault;
  assign int_mask_d  = (wr_do & wa_mask)
                     ? ((int_mask_q & ~wmask_units) | wdata_units)
                     : int_mask_q;

  // Strobe lanes seen at the unit bit positions
  generate
    for (u = 0; u < NU; u++) begin : g_wm
      assign wmask_units[u] = wmask[dsg_pkg::DSG_UNIT_BIT[u]];
    end
  endgenerate

  // Read data selection
  wire [31:0] rd_word = ra_ds_en ? ds_en_q
                      : ra_gates ? gates_word
                      : ra_stat  ? stat_word
                      : ra_mask  ? mask_word
                      : 32'h0000_0000;

  // Irq comes from flops, one edge behind status, so it never glitches
  // Register file
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ds_en_q    <= dsg_pkg::DSG_DS_EN_RESET;
      int_stat_q <= dsg_pkg::DSG_UNITS_ZERO;
      int_mask_q <= dsg_pkg::DSG_UNITS_ZERO;
      irq_q      <= 1'b0;
    end else begin
      ds_en_q    <= ds_en_d;
      int_stat_q <= int_stat_d;
      int_mask_q <= int_mask_d;
      irq_q      <= |(int_stat_q & int_mask_q);
    end
  end

  // Write channels
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= dsg_pkg::DSG_RESP_OKAY;
      aw_addr_q <= '0;
      w_data_q  <= 32'h0000_0000;
      w_strb_q  <= 4'h0;
    end else begin
      aw_have_q <= aw_have_d;
      w_have_q  <= w_have_d;
      awready_q <= ~aw_have_d & ~bvalid_d;
      wready_q  <= ~w_have_d & ~bvalid_d;
      bvalid_q  <= bvalid_d;
      if (aw_hs) begin
        aw_addr_q <= s_axi_awaddr_i;
      end
      if (w_hs) begin
        w_data_q <= s_axi_wdata_i;
        w_strb_q <= s_axi_wstrb_i;
      end
      if (wr_do) begin
        bresp_q <= wa_hit ? dsg_pkg::DSG_RESP_OKAY
                          : dsg_pkg::DSG_RESP_SLVERR;
      end
    end
  end

  // Read channel; one read in flight keeps the data register simple
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= dsg_pkg::DSG_RESP_OKAY;
    end else begin
      arready_q <= ~rvalid_d;
      rvalid_q  <= rvalid_d;
      if (ar_hs) begin
        rdata_q <= rd_word;
        rresp_q <= ra_hit ? dsg_pkg::DSG_RESP_OKAY
                          : dsg_pkg::DSG_RESP_SLVERR;
      end
    end
  end

  assign unit_clk_en_o   = unit_clk_en_q_w;
  assign unit_fault_o    = gate_bus.fault;
  assign irq_o           = irq_q;
  assign s_axi_awready_o = awready_q;
  assign s_axi_wready_o  = wready_q;
  assign s_axi_bvalid_o  = bvalid_q;
  assign s_axi_bresp_o   = bresp_q;
  assign s_axi_arready_o = arready_q;
  assign s_axi_rvalid_o  = rvalid_q;
  assign s_axi_rdata_o   = rdata_q;
  assign s_axi_rresp_o   = rresp_q;

endmodule : dsg_top
`default_nettype wire

// File: sim/dsg_soft_model.sv
// Software side that touches units, one access cycle per request
`timescale 1ns/1ps
`default_nettype none
module dsg_soft_model (
  input  wire logic       clk_i,
  input  wire logic [4:0] hit_i,
  output var  logic [4:0] access_o = 5'h00
);
  // Registered so an access always starts just after an edge
  always_ff @(posedge clk_i) access_o <= hit_i;
endmodule : dsg_soft_model
`default_nettype wire

// File: sim/dsg_top_properties.sv
// Assertions on gating, fault and bus timing of the gating block
`timescale 1ns/1ps
`default_nettype none
module dsg_top_props (
  input wire logic        clk_i,
  input wire logic        rst_n_i,
  input wire logic        deep_sleep_i,
  input wire logic        sleep_i,
  input wire logic        auto_gating_select_i,
  input wire logic [31:0] run_mode_unit_clock_enables_i,
  input wire logic [31:0] sleep_mode_unit_clock_enables_i,
  input wire logic [4:0]  unit_access_i,
  input wire logic [4:0]  unit_clk_en_o,
  input wire logic [4:0]  unit_fault_o,
  input wire logic        s_axi_bvalid_o,
  input wire logic        s_axi_bready_i,
  input wire logic        s_axi_rvalid_o,
  input wire logic        s_axi_rready_i,
  input wire logic        s_axi_arready_o
);
  wire logic [31:0] rs      = run_mode_unit_clock_enables_i;
  wire logic [31:0] ss      = sleep_mode_unit_clock_enables_i;
  wire logic [4:0]  run_map = {rs[25], rs[24], rs[20], rs[6], rs[3]};
  wire logic [4:0]  slp_map = {ss[25], ss[24], ss[20], ss[6], ss[3]};
  wire logic        use_ds  = auto_gating_select_i & deep_sleep_i;
  wire logic        use_slp = auto_gating_select_i & sleep_i & !deep_sleep_i;

  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence gated_hit;
    |(unit_access_i & ~unit_clk_en_o);
  endsequence

  fault_cause_a: assert property (
    unit_fault_o == ($past(unit_access_i) & ~$past(unit_clk_en_o)))
    else $error("fault does not match gated access");
  hit_fault_a: assert property (
    gated_hit |=> unit_fault_o != 5'h00)
    else $error("gated access gave no fault");
  run_select_a: assert property (
    !use_ds && !use_slp |=> unit_clk_en_o == $past(run_map))
    else $error("run set not applied");
  sleep_select_a: assert property (
    use_slp |=> unit_clk_en_o == $past(slp_map))
    else $error("sleep set not applied");
  reset_clear_a: assert property (
    $rose(rst_n_i) |-> unit_clk_en_o == 5'h00 && unit_fault_o == 5'h00)
    else $error("gates not cleared by reset");
  b_retire_a: assert property (
    s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o)
    else $error("write response repeated");
  r_retire_a: assert property (
    s_axi_rvalid_o && s_axi_rready_i |=> !s_axi_rvalid_o)
    else $error("read data repeated");
  ar_refused_a: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
    else $error("read taken while data pending");
endmodule : dsg_top_props

bind dsg_top dsg_top_props u_props (
  .clk_i, .rst_n_i, .deep_sleep_i, .sleep_i, .auto_gating_select_i,
  .run_mode_unit_clock_enables_i, .sleep_mode_unit_clock_enables_i,
  .unit_access_i, .unit_clk_en_o, .unit_fault_o, .s_axi_bvalid_o,
  .s_axi_bready_i, .s_axi_rvalid_o, .s_axi_rready_i, .s_axi_arready_o
);
`default_nettype wire

// File: sim/dsg_top_tb.sv
// Register, gating and fault tests for the deep-sleep gating block
`timescale 1ns/1ps
`default_nettype none
module dsg_top_tb;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, run_set, slp_set;
  logic [4:0]  hit, access, clk_en, fault;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic        clk_i, rst_n_i, deep, slp, auto_sel, irq;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  int          fails, n_tests;

  dsg_soft_model u_soft (.clk_i, .hit_i(hit), .access_o(access));

  dsg_top u_dut (
    .clk_i, .rst_n_i, .deep_sleep_i(deep), .sleep_i(slp),
    .auto_gating_select_i(auto_sel),
    .run_mode_unit_clock_enables_i(run_set),
    .sleep_mode_unit_clock_enables_i(slp_set),
    .unit_access_i(access), .unit_clk_en_o(clk_en),
    .unit_fault_o(fault), .irq_o(irq),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
    .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready)
  );

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  task automatic give_verdict();
    $display("Checks %0d, errors %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : give_verdict

  task automatic chk(input string what, input logic [31:0] exp, got);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    @(posedge clk_i);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge clk_i);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    chk("bresp", er, bresp);
  endtask : wr

  task automatic rd(input string what, input logic [11:0] a,
                    input logic [31:0] ed, input logic [1:0] er);
    @(posedge clk_i);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge clk_i);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    chk(what, ed, rdata);
    chk("rresp", er, rresp);
  endtask : rd

  task automatic tick(input int k);
    repeat (k) @(posedge clk_i);
  endtask : tick

  // Access one edge after hit, fault next, then status, then irq
  task automatic touch(input logic [4:0] m);
    @(posedge clk_i);
    hit <= m;
    @(posedge clk_i);
    hit <= 5'h00;
    tick(4);
  endtask : touch

  function automatic logic [31:0] bits_of(input logic [4:0] m);
    bits_of = 32'h0000_0000;
    for (int k = 0; k < 5; k++)
      if (m[k]) bits_of[dsg_pkg::DSG_UNIT_BIT[k]] = 1'b1;
  endfunction : bits_of

  initial begin
    #50us;
    fails++;
    give_verdict();
  end

  initial begin
    {deep, slp, auto_sel, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, hit, rst_n_i, fails, n_tests} = '0;
    run_set = 32'h0100_0008;
    slp_set = 32'h0010_0000;
    wstrb   = 4'hf;
    tick(6);
    rst_n_i <= 1'b1;
    rd("ds reset", 12'h120, 32'h0000_0040, 2'h0);
    rd("mask reset", 12'h12c, 32'h0, 2'h0);
    wr(12'h120, 32'hffff_ffff, 2'h0);
    rd("ds fields", 12'h120, 32'h0310_0048, 2'h0);
    wr(12'h200, 32'h1, 2'h2);
    rd("unmapped", 12'h200, 32'h0, 2'h2);
    auto_sel <= 1'b1;
    wr(12'h120, 32'h0200_0040, 2'h0);
    tick(3);
    chk("run gates", 5'h09, clk_en);
    deep <= 1'b1;
    tick(3);
    chk("deep gates", 5'h12, clk_en);
    deep <= 1'b0;
    slp  <= 1'b1;
    tick(3);
    chk("sleep gates", 5'h04, clk_en);
    slp  <= 1'b0;
    deep <= 1'b1;
    for (int k = 0; k < 5; k++) begin
      wr(12'h120, bits_of(5'h01 << k), 2'h0);
      tick(2);
      chk("unit gate", 5'h01 << k, clk_en);
      rd("gate state", 12'h124, bits_of(5'h01 << k), 2'h0);
      touch(5'h1f);
      rd("faults", 12'h128, bits_of(~(5'h01 << k)), 2'h0);
      wr(12'h128, 32'hffff_ffff, 2'h0);
      rd("status clear", 12'h128, 32'h0, 2'h0);
    end
    wr(12'h120, 32'h0, 2'h0);
    wr(12'h12c, 32'h0010_0000, 2'h0);
    touch(5'h01);
    chk("irq masked", 1'b0, irq);
    touch(5'h04);
    chk("irq raised", 1'b1, irq);
    wr(12'h128, 32'h0010_0000, 2'h0);
    tick(2);
    chk("irq cleared", 1'b0, irq);
    rd("status left", 12'h128, 32'h0000_0008, 2'h0);
    auto_sel <= 1'b0;
    tick(3);
    chk("no auto gates", 5'h09, clk_en);
    rst_n_i <= 1'b0;
    tick(2);
    rst_n_i <= 1'b1;
    rd("ds rereset", 12'h120, 32'h0000_0040, 2'h0);
    rd("stat reset", 12'h128, 32'h0, 2'h0);
    give_verdict();
  end
endmodule : dsg_top_tb
`default_nettype wire
